// [core/spi_pkg.sv]
// constants shared by the serial port block: register map, fields, timing
// assumes a single 40 MHz clock and a 32-bit AXI4-Lite register bus
`default_nettype none
package spi_pkg;
  // bus geometry
  localparam int unsigned SPI_ADDR_W = 12;
  localparam int unsigned SPI_DATA_W = 32;
  // register indexes, byte address is four times the index
  localparam logic [9:0] SPI_CTRL_IDX = 10'h042;
  localparam logic [9:0] SPI_STAT_IDX = 10'h043;
  localparam logic [9:0] SPI_DATA_IDX = 10'h044;
  // serial_control fields
  localparam int unsigned SPI_CB_INT_EN    = 7;
  localparam int unsigned SPI_CB_PORT_EN   = 6;
  localparam int unsigned SPI_CB_MASTER    = 4;
  localparam int unsigned SPI_CB_IDLE_LVL  = 3;
  localparam int unsigned SPI_CB_PHASE     = 2;
  localparam int unsigned SPI_CB_RATE_HI   = 1;
  localparam int unsigned SPI_CB_RATE_LO   = 0;
  localparam logic [7:0]  SPI_CTRL_RST     = 8'h00;
  // serial_status fields
  localparam int unsigned SPI_SB_DONE      = 7;
  localparam int unsigned SPI_SB_WRITE_COLLISION_FLAG      = 6;
  localparam int unsigned SPI_SB_MODE_FAULT_FLAG      = 4;
  localparam logic [7:0]  SPI_DATA_RST     = 8'h00;
  // bus answers
  localparam logic [1:0]  SPI_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SPI_RESP_SLVERR  = 2'h2;
  // timing: system clock, processor clock, serial limits
  localparam int unsigned SPI_CLOCK_HZ     = 40_000_000;
  localparam int unsigned SPI_PROC_HZ      = 4_000_000;
  localparam int unsigned SPI_MASTER_MAX_HZ = 2_000_000;
  localparam int unsigned SPI_SLAVE_MAX_HZ = 4_000_000;
  localparam int unsigned SPI_TICK_CYC     = SPI_CLOCK_HZ / SPI_PROC_HZ;
  localparam int unsigned SPI_SLAVE_HALF_CYC = SPI_CLOCK_HZ / (2 * SPI_SLAVE_MAX_HZ);
  // mask option: pre-divide the processor clock by two
  localparam logic        SPI_MASK_DIV2    = 1'b0;
  localparam int unsigned SPI_PREMUL       = SPI_MASK_DIV2 ? 2 : 1;
  // processor clock divisions per rate code
  localparam int unsigned SPI_RATE_DIV [4] = '{2, 4, 16, 32};
  localparam logic [3:0]  SPI_LAST_EDGE    = 4'hF;
  localparam int unsigned SPI_HALF_W       = 16;
  // transfer state
  typedef enum logic [0:0] {
    SPI_IDLE = 1'b0,
    SPI_RUN  = 1'b1
  } spi_xfer_e;
endpackage
`default_nettype wire

// [core/spi_port.sv]
// serial peripheral port: master or slave, registers over AXI4-Lite
// assumes pins arrive asynchronously; pad logic resolves the enables
//
// What this block does
// - master write to data register starts a transfer; clock made from processor clock
// - master loads written byte into 8-bit shift register, shifts out on MOSI
// - after eight bits the shift register is copied to the read buffer
// - slave loads written byte and shifts it out on MISO
// - both lines carry most significant bit first
// - master presents each bit half a clock before the latching edge
// - one shift register for both directions; received byte replaces sent one
// - transfer_done_flag in status sets when a byte completes
// - master_select picks role; master drives MOSI, reads MISO
// - slave MISO released while select high, driven while select low
// - select input only counts while port_enable is set
// - slave with phase 0 and select low refuses data writes
// - unselected slave ignores serial clock and MOSI
// - master seeing select low drops master and enable, flags mode fault
// - serial function disables pull-up and uses push-pull drive
// - master rate at most 2 MHz; slave accepts up to 4 MHz
// - mask option may halve processor clock before the rate generator
// - idle level and phase choose one of four timings, both ends alike
// - slave starts on select low plus clock from the master
// - selected slave puts its first bit on MISO when select drops
// - write during a transfer sets write_collision_flag, transfer continues
// - interrupt request when enabled and done or mode fault flag set
// - idle master clock rests at clock_idle_level
// - rate_select picks one of four divisions; no effect as slave
//
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
module spi_port (
  input  wire logic                          i_clock,
  input  wire logic                          i_rst,
  input  wire logic [spi_pkg::SPI_ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                          i_s_axi_awvalid,
  output var  logic                          o_s_axi_awready,
  input  wire logic [spi_pkg::SPI_DATA_W-1:0] i_s_axi_wdata,
  input  wire logic [3:0]                    i_s_axi_wstrb,
  input  wire logic                          i_s_axi_wvalid,
  output var  logic                          o_s_axi_wready,
  output var  logic [1:0]                    o_s_axi_bresp,
  output var  logic                          o_s_axi_bvalid,
  input  wire logic                          i_s_axi_bready,
  input  wire logic [spi_pkg::SPI_ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                          i_s_axi_arvalid,
  output var  logic                          o_s_axi_arready,
  output var  logic [spi_pkg::SPI_DATA_W-1:0] o_s_axi_rdata,
  output var  logic [1:0]                    o_s_axi_rresp,
  output var  logic                          o_s_axi_rvalid,
  input  wire logic                          i_s_axi_rready,
  input  wire logic                          i_sck,
  output var  logic                          o_sck,
  output var  logic                          o_sck_oe,
  input  wire logic                          i_mosi,
  output var  logic                          o_mosi,
  output var  logic                          o_mosi_oe,
  input  wire logic                          i_miso,
  output var  logic                          o_miso,
  output var  logic                          o_miso_oe,
  input  wire logic                          i_port_c_bit_five_n,
  input  wire logic                          i_port_c_pullup_enable,
  output var  logic                          o_pullup_active,
  output var  logic                          o_irq
);
  import spi_pkg::*;

  // register state
  logic [7:0]  ctrl;
  logic [7:0]  shreg;
  logic [7:0]  rbuf;
  logic        done_flag;
  logic        write_collision_flag_flag;
  logic        mode_fault_flag_flag;
  logic        stat_seen;
  logic        mode_fault_flag_seen;
  // bus state
  logic        aw_have;
  logic        w_have;
  logic [9:0]  aw_idx;
  logic [7:0]  w_byte;
  logic        w_lane0;
  // transfer state
  spi_xfer_e   xfer;
  logic [3:0]  ecnt;
  logic        rbit;
  logic [SPI_HALF_W-1:0] half_cnt;
  logic        sck_phase;
  // input synchronisers and filtered levels
  logic [2:0]  sck_sy, mosi_sy, miso_sy, ss_sy;
  logic        sck_f, sck_fq, mosi_f, miso_f, ss_f;
  // decoded controls and strobes
  logic        pe, master, clock_idle_level, clock_phase_select, ss_low;
  logic        wr_go, rd_go, data_wr, data_rd, stat_rd, ctrl_wr;
  logic [9:0]  ar_idx;
  logic        busy, slave_block, m_start, m_edge, s_edge, edge_ev;
  logic        din, is_sample, is_shift, complete, mode_fault, slave_abort, mosi_hold;
  logic [7:0]  complete_val;
  logic [SPI_HALF_W-1:0] half_cyc;

  // master half period in system cycles for the selected rate
  function automatic logic [SPI_HALF_W-1:0] half_of(input logic [1:0] code);
    int unsigned v;
    v = (SPI_RATE_DIV[code] * SPI_TICK_CYC * SPI_PREMUL) / 2;
    return v[SPI_HALF_W-1:0];
  endfunction

  // control fields and select qualification
  assign pe      = ctrl[SPI_CB_PORT_EN];
  assign master  = ctrl[SPI_CB_MASTER];
  assign clock_idle_level    = ctrl[SPI_CB_IDLE_LVL];
  assign clock_phase_select    = ctrl[SPI_CB_PHASE];
  assign ss_low  = pe & ~ss_f;
  assign half_cyc = half_of(ctrl[SPI_CB_RATE_HI:SPI_CB_RATE_LO]);

  // three-stage synchronisers on every pin input
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sck_sy  <= 3'h0;
      mosi_sy <= 3'h0;
      miso_sy <= 3'h0;
      ss_sy   <= 3'h7;
    end else begin
      sck_sy  <= {sck_sy[1:0], i_sck};
      mosi_sy <= {mosi_sy[1:0], i_mosi};
      miso_sy <= {miso_sy[1:0], i_miso};
      ss_sy   <= {ss_sy[1:0], i_port_c_bit_five_n};
    end
  end

  // a level counts once the second and third stages agree
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sck_f  <= 1'b0;
      sck_fq <= 1'b0;
      mosi_f <= 1'b0;
      miso_f <= 1'b0;
      ss_f   <= 1'b1;
    end else begin
      if (sck_sy[1] == sck_sy[2]) sck_f <= sck_sy[2];
      if (mosi_sy[1] == mosi_sy[2]) mosi_f <= mosi_sy[2];
      if (miso_sy[1] == miso_sy[2]) miso_f <= miso_sy[2];
      if (ss_sy[1] == ss_sy[2]) ss_f <= ss_sy[2];
      sck_fq <= (!master && ss_low) ? sck_f : clock_idle_level;
    end
  end

  // bus strobes: write fires once address and data are both held
  assign wr_go   = aw_have && w_have && !o_s_axi_bvalid;
  assign rd_go   = i_s_axi_arvalid && o_s_axi_arready;
  assign ar_idx  = i_s_axi_araddr[11:2];
  assign data_wr = wr_go && w_lane0 && (aw_idx == SPI_DATA_IDX);
  assign ctrl_wr = wr_go && w_lane0 && (aw_idx == SPI_CTRL_IDX);
  assign data_rd = rd_go && (ar_idx == SPI_DATA_IDX);
  assign stat_rd = rd_go && (ar_idx == SPI_STAT_IDX);

  // transfer events: master rate generator edge or qualified slave edge
  assign busy        = (xfer == SPI_RUN);
  assign slave_block = !master && !clock_phase_select && ss_low;
  assign m_start     = data_wr && master && pe && !busy;
  assign m_edge      = master && busy && (half_cnt == half_cyc - 16'h0001);
  assign s_edge      = !master && ss_low && (sck_f != sck_fq);
  assign edge_ev     = m_edge || s_edge;
  assign din         = master ? miso_f : mosi_f;
  assign is_sample   = edge_ev && (ecnt[0] == clock_phase_select);
  assign is_shift    = edge_ev && !is_sample && !(clock_phase_select && ecnt == 4'h0);
  assign complete    = edge_ev && (ecnt == SPI_LAST_EDGE);
  assign complete_val = is_sample ? {shreg[6:0], din} : {shreg[6:0], rbit};
  assign mode_fault  = pe && master && ss_low;
  assign slave_abort = !master && busy && !ss_low;

  // write address and data channels, taken in either order
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_idx  <= 10'h000;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= SPI_RESP_OKAY;
    end else begin
      o_s_axi_awready <= !aw_have && !(i_s_axi_awvalid && o_s_axi_awready);
      o_s_axi_wready  <= !w_have && !(i_s_axi_wvalid && o_s_axi_wready);
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_have <= 1'b1;
        aw_idx  <= i_s_axi_awaddr[11:2];
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_have  <= 1'b1;
        w_byte  <= i_s_axi_wdata[7:0];
        w_lane0 <= i_s_axi_wstrb[0];
      end
      if (wr_go) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (aw_idx == SPI_CTRL_IDX || aw_idx == SPI_DATA_IDX ||
                           aw_idx == SPI_STAT_IDX) ? SPI_RESP_OKAY : SPI_RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        aw_have         <= 1'b0;
        w_have          <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= SPI_RESP_OKAY;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !rd_go;
      if (rd_go) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp  <= SPI_RESP_OKAY;
        case (ar_idx)
          SPI_CTRL_IDX: o_s_axi_rdata <= {24'h000000, ctrl};
          SPI_STAT_IDX: o_s_axi_rdata <= {24'h000000, done_flag, write_collision_flag_flag, 1'b0,
                                          mode_fault_flag_flag, 4'h0};
          SPI_DATA_IDX: o_s_axi_rdata <= {24'h000000, rbuf};
          default: begin
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= SPI_RESP_SLVERR;
          end
        endcase
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid  <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // control register; a mode fault drops master and port enable
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl <= SPI_CTRL_RST;
    end else begin
      if (ctrl_wr) ctrl <= {w_byte[7:6], 1'b0, w_byte[4:0]};
      if (mode_fault) begin
        ctrl[SPI_CB_MASTER]  <= 1'b0;
        ctrl[SPI_CB_PORT_EN] <= 1'b0;
      end
    end
  end

  // status flags: status read arms the clear, a later access clears; set wins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_flag <= 1'b0;
      write_collision_flag_flag <= 1'b0;
      mode_fault_flag_flag <= 1'b0;
      stat_seen <= 1'b0;
      mode_fault_flag_seen <= 1'b0;
    end else begin
      if (stat_rd) stat_seen <= done_flag || write_collision_flag_flag;
      else if (data_wr || data_rd) stat_seen <= 1'b0;
      if (stat_rd) mode_fault_flag_seen <= mode_fault_flag_flag;
      else if (ctrl_wr) mode_fault_flag_seen <= 1'b0;
      if (complete) done_flag <= 1'b1;
      else if (stat_seen && (data_wr || data_rd)) done_flag <= 1'b0;
      if (data_wr && (busy || slave_block)) write_collision_flag_flag <= 1'b1;
      else if (stat_seen && (data_wr || data_rd)) write_collision_flag_flag <= 1'b0;
      if (mode_fault) mode_fault_flag_flag <= 1'b1;
      else if (mode_fault_flag_seen && ctrl_wr) mode_fault_flag_flag <= 1'b0;
    end
  end

  // master rate generator: half-period counter and clock phase
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      half_cnt  <= 16'h0000;
      sck_phase <= 1'b0;
    end else if (!master || !busy || mode_fault) begin
      half_cnt  <= 16'h0000;
      sck_phase <= 1'b0;
    end else if (m_edge) begin
      half_cnt  <= 16'h0000;
      sck_phase <= ~sck_phase;
    end else begin
      half_cnt  <= half_cnt + 16'h0001;
    end
  end

  // shared shift register, edge counter and read buffer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      xfer  <= SPI_IDLE;
      ecnt  <= 4'h0;
      rbit  <= 1'b0;
      shreg <= SPI_DATA_RST;
      rbuf  <= SPI_DATA_RST;
    end else if (mode_fault || slave_abort) begin
      xfer <= SPI_IDLE;
      ecnt <= 4'h0;
    end else if (data_wr && !busy && !slave_block) begin
      shreg <= w_byte;
      if (m_start) xfer <= SPI_RUN;
    end else if (edge_ev) begin
      ecnt <= ecnt + 4'h1;
      if (!master) xfer <= SPI_RUN;
      if (is_sample) rbit <= din;
      if (is_shift) shreg <= {shreg[6:0], rbit};
      if (complete) begin
        shreg <= complete_val;
        rbuf  <= complete_val;
        xfer  <= SPI_IDLE;
        ecnt  <= 4'h0;
      end
    end
  end

  // pin drivers, interrupt request and pull-up control, all registered
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sck           <= 1'b0;
      o_sck_oe        <= 1'b0;
      o_mosi          <= 1'b0;
      o_mosi_oe       <= 1'b0;
      o_miso          <= 1'b0;
      o_miso_oe       <= 1'b0;
      o_irq           <= 1'b0;
      o_pullup_active <= 1'b0;
      mosi_hold       <= 1'b0;
    end else begin
      mosi_hold       <= complete;                     // keeps mosi still over the last edge
      o_sck           <= clock_idle_level ^ sck_phase;
      o_sck_oe        <= pe && master && !mode_fault;
      o_mosi          <= mosi_hold ? o_mosi : shreg[7];
      o_mosi_oe       <= pe && master && !mode_fault;
      o_miso          <= shreg[7];
      o_miso_oe       <= pe && !master && ss_low;
      o_irq           <= ctrl[SPI_CB_INT_EN] && (done_flag || mode_fault_flag_flag);
      o_pullup_active <= i_port_c_pullup_enable && !pe;
    end
  end

  // checks on the logic above
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_load;
    m_start;
  endsequence
  sequence s_complete;
    complete;
  endsequence

  property p_write_collision_flag;
    data_wr && busy |=> write_collision_flag_flag;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision not flagged");
  property p_block;
    data_wr && slave_block |=> write_collision_flag_flag && $stable(shreg);
  endproperty
  a_block: assert property (p_block) else $error("blocked slave write loaded");
  property p_done;
    s_complete |=> done_flag && !busy;
  endproperty
  a_done: assert property (p_done) else $error("done flag missing");
  property p_rbuf;
    s_complete |=> rbuf == $past(complete_val);
  endproperty
  a_rbuf: assert property (p_rbuf) else $error("read buffer not copied");
  property p_mode_fault_flag;
    mode_fault |=> !master && !pe && mode_fault_flag_flag ##1 !o_mosi_oe && !o_sck_oe;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault handling wrong");
  property p_miso_oe;
    !master |=> o_miso_oe == $past(pe && ss_low);
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("slave miso enable wrong");
  property p_idle_sck;
    !busy |=> o_sck == $past(clock_idle_level);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("idle clock level wrong");
  property p_half;
    s_load |=> !m_edge [*8];
  endproperty
  a_half: assert property (p_half) else $error("master edge too early");
  property p_msb;
    s_load |=> ##1 o_mosi == $past(w_byte[7], 2);
  endproperty
  a_msb: assert property (p_msb) else $error("msb not presented first");
  property p_ignore;
    !master && !ss_low && !data_wr |=> $stable(shreg) && $stable(rbuf);
  endproperty
  a_ignore: assert property (p_ignore) else $error("unselected slave shifted");
endmodule // spi_port
`default_nettype wire

// [verif/spi_far_model.sv]
// far-side serial device: separate send and receive shift registers answering a master
// assumes the bench drives its select and mode bits like the block's
`default_nettype none
module spi_far_model (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_sel_n,
  input  wire logic       i_idle,
  input  wire logic       i_clock_phase_select,
  input  wire logic [7:0] i_tx,
  output var  logic       o_miso,
  output var  logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  int         n;
  wire logic  lead = i_sck ^ i_idle;
  initial o_miso = 1'b0;
  // load on select, same mode as the block
  always @(negedge i_sel_n) begin
    sh = i_tx;
    n = 0;
  end
  // leading edge: sample (phase 0) or shift after the first (phase 1)
  always @(posedge lead) if (!i_sel_n) begin
    if (!i_clock_phase_select) o_rx = {o_rx[6:0], i_mosi};
    else if (n != 0) sh = {sh[6:0], 1'b0};
    n++;
  end
  // trailing edge: the other half of the pair
  always @(negedge lead) if (!i_sel_n) begin
    if (i_clock_phase_select) o_rx = {o_rx[6:0], i_mosi};
    else sh = {sh[6:0], 1'b0};
  end
  // released line shows the inverse of its last level
  always @(i_sel_n or sh) begin
    if (!i_sel_n) o_miso = sh[7];
    else o_miso = ~o_miso;
  end
endmodule // spi_far_model
`default_nettype wire

// [verif/serial_peripheral_interface_bench.sv]
// self-checking bench: register bus, master in four modes, slave, fault
// assumes the design package and the far-side model are compiled first
`default_nettype none
module serial_peripheral_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rr;
  logic        bsck, bmosi, ss_n, pu, fsel_n, fidle, fcpha, fmiso, pu_act, irq;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [7:0]  ftx, frx, got;
  logic [31:0] seed = 32'h000041CF;
  int          n_errors = 0;
  int          samples_checked = 0;
  wire logic   sck_w = sck_oe ? sck_o : bsck;
  wire logic   mosi_w = mosi_oe ? mosi_o : bmosi;
  wire logic   miso_w = miso_oe ? miso_o : fmiso;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  spi_port DUT (.i_clock(clk), .i_rst(rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_sck(sck_w), .o_sck(sck_o), .o_sck_oe(sck_oe),
    .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe), .i_miso(miso_w),
    .o_miso(miso_o), .o_miso_oe(miso_oe), .i_port_c_bit_five_n(ss_n),
    .i_port_c_pullup_enable(pu), .o_pullup_active(pu_act), .o_irq(irq));
  spi_far_model FAR (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(fsel_n), .i_idle(fidle),
    .i_clock_phase_select(fcpha), .i_tx(ftx), .o_miso(fmiso), .o_rx(frx));
  // expectation helpers
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] stat(input logic d, input logic w, input logic m);
    return {d, w, 1'b0, m, 4'h0};
  endfunction
  function automatic logic [7:0] half(input logic [1:0] r);
    return 8'(SPI_RATE_DIV[r] * SPI_TICK_CYC * SPI_PREMUL / 2);
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bus write: address and data together, each released when taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    logic [1:0] r;
    rd({idx, 2'b00}, got, r);
    chk8(got, e);
  endtask
  task automatic wait_done();
    logic [1:0] r;
    do rd({SPI_STAT_IDX, 2'b00}, got, r); while (got[7] !== 1'b1);
  endtask
  // one master byte against the far model, with a colliding write
  task automatic master(input logic [1:0] r, input logic pol, input logic ph);
    int         h;
    logic [7:0] a;
    logic [7:0] b;
    a = rnd8();
    b = rnd8();
    wr(SPI_CTRL_IDX, {3'b010, 1'b1, pol, ph, r});
    chk8({6'h00, rr}, {6'h00, SPI_RESP_OKAY});
    cyc(1);
    chk1(pu_act, 1'b0);
    chk1(sck_o, pol);
    fidle <= pol;
    fcpha <= ph;
    ftx <= b;
    @(posedge clk);
    fsel_n <= 1'b0;
    wr(SPI_DATA_IDX, a);
    while (sck_o === pol) @(posedge clk);
    chk1(mosi_o, a[7]);
    h = 0;
    while (sck_o !== pol) begin
      @(posedge clk);
      h++;
    end
    chk8(h[7:0], half(r));
    wr(SPI_DATA_IDX, rnd8());
    wait_done();
    rdc(SPI_STAT_IDX, stat(1'b1, 1'b1, 1'b0));
    rdc(SPI_DATA_IDX, b);
    chk8(frx, a);
    rdc(SPI_STAT_IDX, 8'h00);
    fsel_n <= 1'b1;
  endtask
  // slave byte: clocks while unselected are ignored, then eight cycles
  task automatic slave(input logic pol);
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] seen;
    tx = rnd8();
    rx = rnd8();
    wr(SPI_CTRL_IDX, {4'h4, pol, 3'b000});
    bsck <= pol;
    repeat (4) begin
      cyc(10);
      bmosi <= 1'b1;
      bsck <= ~bsck;
    end
    chk1(miso_oe, 1'b0);
    wr(SPI_DATA_IDX, tx);
    ss_n <= 1'b0;
    cyc(10);
    chk1(miso_oe, 1'b1);
    chk1(miso_o, tx[7]);
    wr(SPI_DATA_IDX, rnd8());
    for (int k = 7; k >= 0; k--) begin
      bmosi <= rx[k];
      cyc(10);
      seen[k] = miso_w;
      bsck <= ~pol;
      cyc(10);
      bsck <= pol;
    end
    cyc(10);
    ss_n <= 1'b1;
    wait_done();
    rdc(SPI_STAT_IDX, stat(1'b1, 1'b1, 1'b0));
    rdc(SPI_DATA_IDX, rx);
    chk8(seen, tx);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {bsck, bmosi, fidle, fcpha, ftx} = '0;
    {ss_n, fsel_n, pu} = 3'b111;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    rdc(SPI_CTRL_IDX, SPI_CTRL_RST);
    rdc(SPI_STAT_IDX, 8'h00);
    rd(12'h200, got, rr);
    chk8({6'h00, rr}, {6'h00, SPI_RESP_SLVERR});
    chk8(got, 8'h00);
    wr(10'h080, 8'h00);
    chk8({6'h00, rr}, {6'h00, SPI_RESP_SLVERR});
    chk1(pu_act, 1'b1);
    for (int i = 0; i < 4; i++) master(i[1:0], i[0], i[1]);
    wr(SPI_CTRL_IDX, 8'hD0);
    ss_n <= 1'b0;
    cyc(10);
    chk1(irq, 1'b1);
    chk1(mosi_oe | sck_oe, 1'b0);
    rdc(SPI_CTRL_IDX, 8'h80);
    rdc(SPI_STAT_IDX, stat(1'b0, 1'b0, 1'b1));
    ss_n <= 1'b1;
    wr(SPI_CTRL_IDX, 8'h00);
    slave(1'b0);
    slave(1'b1);
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule // serial_peripheral_interface_bench
`default_nettype wire
